/* File: common/pps_pkg.sv */
// Purpose: Shared constants and types of the power sequencer
// Assumes: Three supplies, indexed buck, linear one, linear two
// Notes:   Voltage codes are opaque eight-bit settings
package pps_pkg;

  // ---------------------------------------------------------------
  // Supplies and synchroniser lanes
  // ---------------------------------------------------------------
  localparam int NUM_SUP  = 3;
  localparam int BUCK_IDX = 0;
  localparam int LIN1_IDX = 1;
  localparam int LIN2_IDX = 2;
  localparam int SYNC_EN  = 0;
  localparam int SYNC_OT  = 1;
  localparam int SYNC_UV  = 2;
  localparam int SYNC_PG  = 3;
  localparam int SYNC_W   = 6;

  // ---------------------------------------------------------------
  // Power-on and default values
  // ---------------------------------------------------------------
  localparam logic [2:0] EN_POR       = 3'h0;
  localparam logic [2:0] EN_DEF_SEQ   = 3'h7;
  localparam logic [2:0] EN_DEF_NOSEQ = 3'h1;
  localparam logic       RESTART_POR  = 1'h1;
  localparam logic       SEQ_INH_POR  = 1'h0;
  localparam logic       INT_EN_POR   = 1'h0;
  localparam logic       FLAG_POR     = 1'h0;
  localparam logic [7:0] VSEL_BUCK_DEF = 8'h1C;
  localparam logic [7:0] VSEL_LIN1_DEF = 8'h45;
  localparam logic [7:0] VSEL_LIN2_DEF = 8'hD1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PPS_OFF   = 2'b00,
    PPS_RUN   = 2'b01,
    PPS_FAULT = 2'b10
  } pps_state_type;

  typedef struct packed {
    logic       wr;
    logic       restart;
    logic       seq_inh;
    logic [2:0] en;
  } pps_enwr_type;

  typedef struct packed {
    logic wr;
    logic int_en;
    logic clr_uv;
    logic clr_ot;
  } pps_stwr_type;

  typedef struct packed {
    logic       restart;
    logic       seq_inh;
    logic [2:0] en;
  } pps_enable_type;

  typedef struct packed {
    logic       int_en;
    logic       uv_flag;
    logic       ot_flag;
    logic [2:0] pgood;
  } pps_status_type;

endpackage : pps_pkg

/* File: verilog/pps_power_sequencer.sv */
// Purpose: Startup, shutdown, fault and sequencing control of a
//          three-output power management chip
// Assumes: Host register writes arrive already decoded as strobes
// Notes:   rst_b is the power-on reset from supply detection
//
// Function
// RULE_01: Power-on reset loads every host register with its default.
// RULE_02: Enable already high at power-on starts default startup at once.
// RULE_03: Default startup loads voltages, enables, clears inhibit, sets restart.
// RULE_04: Enable pin rising edge starts default startup; level alone does not.
// RULE_05: Enable pin falling edge turns all outputs off, clears enables, bias.
// RULE_06: Falling edge after host shutdown has no further effect.
// RULE_07: Enable bits switch supplies; disabled ones are skipped in sequence.
// RULE_08: Host never mixes enable pin edges with register control.
// RULE_09: Voltage register writes take effect at once.
// RULE_10: Fault turns outputs off, sets flag, reloads defaults, keeps restart. Code clears the enables instead of loading defaults when restart is low.
// RULE_11: Restart bit high restarts after fault clears; low keeps outputs off.
// RULE_12: Shutdown by pin or cleared enables is accepted anytime, even faulted.
// RULE_13: Fault flags clear only by power-on reset or writing one.
// RULE_14: Over-temperature keeps bias, logs flag, restarts if restart bit set.
// RULE_15: Undervoltage keeps bias, outputs off, logs flag, restarts likewise.
// RULE_16: Supply collapse falls into power-on reset, clearing flags.
// RULE_17: Power-good flag per output follows the hysteretic comparator.
// RULE_18: Interrupt enabled drives interrupt low while either fault flag set.
// RULE_19: Writing one clears flag and interrupt; persisting fault resets them.
// RULE_20: Interrupt behaviour ignores the restart bit.
// RULE_21: Interrupt enable resets to zero.
// RULE_22: Variant without sequencing starts one supply; inhibit reads zero.
// RULE_23: Chain order buck, linear one, linear two, gated by power good.
// RULE_24: Inhibit bit zero permits sequencing, one disables it.
// RULE_25: Pin and comparator inputs are synchronised before use.
`timescale 1ns/1ps

module pps_power_sequencer #(
  parameter bit         SEQ_CAPABLE = 1'b1,
  parameter logic [7:0] VSEL_BUCK   = pps_pkg::VSEL_BUCK_DEF,
  parameter logic [7:0] VSEL_LIN1   = pps_pkg::VSEL_LIN1_DEF,
  parameter logic [7:0] VSEL_LIN2   = pps_pkg::VSEL_LIN2_DEF
) (
  input  wire logic                  mclk,           // 10 MHz clock
  input  wire logic                  rst_b,          // Power-on reset
  input  wire logic                  en_pin,         // Enable pin
  input  wire logic                  overtemp_cmp,   // Die too hot
  input  wire logic                  undervolt_cmp,  // Input too low
  input  wire logic [2:0]            pgood_cmp,      // Output in range
  input  wire pps_pkg::pps_enwr_type enable_wr,      // Enable reg write
  input  wire pps_pkg::pps_stwr_type status_wr,      // Status reg write
  input  wire logic [2:0]            vsel_wr,        // Voltage reg write
  input  wire logic [7:0]            vsel_wdata,     // Voltage write data
  output pps_pkg::pps_enable_type    enable_rd,      // Enable reg value
  output pps_pkg::pps_status_type    status_rd,      // Status reg value
  output logic [2:0][7:0]            vsel_code,      // Voltage settings
  output logic [2:0]                 supply_on,      // Supply switch-on
  output logic                       bias_on,        // Internal bias
  output logic                       fault_irq_n_o,  // Interrupt level
  output logic                       fault_irq_n_oe_n // Low drives pin
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  localparam logic [2:0] EN_DEF =
    SEQ_CAPABLE ? pps_pkg::EN_DEF_SEQ : pps_pkg::EN_DEF_NOSEQ;

  logic [pps_pkg::SYNC_W-1:0] sync1_ff;
  logic [pps_pkg::SYNC_W-1:0] sync2_ff;
  logic                       en_prev_ff;
  logic                       fault_prev_ff;
  logic                       restart_pend_ff;
  pps_pkg::pps_state_type     state_ff;
  pps_pkg::pps_state_type     nxt_state;
  logic [2:0]                 en_ff;
  logic                       restart_ff;
  logic                       seq_inh_ff;
  logic                       int_en_ff;
  logic                       ot_flag_ff;
  logic                       uv_flag_ff;
  logic [2:0]                 pgood_ff;
  logic [2:0][7:0]            vsel_ff;
  logic [2:0]                 supply_on_ff;
  logic                       bias_on_ff;
  logic                       irq_oe_n_ff;
  logic                       irq_lvl_ff;
  logic [2:0]                 nxt_supply;
  logic [2:0]                 seq_gate;
  logic [2:0]                 pg_s;
  logic                       en_s;
  logic                       fault_s;
  logic                       en_rise;
  logic                       en_fall;
  logic                       fault_rise;
  logic                       fault_fall;
  logic                       host_all_off;
  logic                       default_start;
  logic                       seq_off;

  // Default code of one supply
  function automatic logic [7:0] vsel_default(input int idx);
    case (idx)
      pps_pkg::BUCK_IDX: vsel_default = VSEL_BUCK;
      pps_pkg::LIN1_IDX: vsel_default = VSEL_LIN1;
      default:           vsel_default = VSEL_LIN2;
    endcase
  endfunction : vsel_default

  // ---------------------------------------------------------------
  // Input synchronisers and edge detection
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {pgood_cmp, undervolt_cmp, overtemp_cmp, en_pin};
      sync2_ff <= sync1_ff; // [RULE_25]
    end
  end

  assign en_s    = sync2_ff[pps_pkg::SYNC_EN];
  assign fault_s = sync2_ff[pps_pkg::SYNC_OT] | sync2_ff[pps_pkg::SYNC_UV];
  assign pg_s    = sync2_ff[pps_pkg::SYNC_PG +: 3];

  // Previous level resets low, so a pin high at power-on reads as a rise
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      en_prev_ff    <= 1'b0; // [RULE_02]
      fault_prev_ff <= 1'b0;
    end else begin
      en_prev_ff    <= en_s;
      fault_prev_ff <= fault_s;
    end
  end

  assign en_rise      = en_s & ~en_prev_ff; // [RULE_04] [RULE_02]
  assign en_fall      = ~en_s & en_prev_ff; // [RULE_05]
  assign fault_rise   = fault_s & ~fault_prev_ff; // [RULE_10]
  assign fault_fall   = ~fault_s & fault_prev_ff;
  assign host_all_off = enable_wr.wr & (enable_wr.en == 3'h0); // [RULE_12]
  // Pin edges take priority, except a rise against an all-off write in the power state; mixing both controls is not supported
  assign default_start = en_rise | (fault_fall & restart_pend_ff); // [RULE_11]

  // ---------------------------------------------------------------
  // Restart pending across a fault
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      restart_pend_ff <= 1'b0;
    end else if (en_fall || host_all_off || fault_fall) begin
      restart_pend_ff <= 1'b0; // [RULE_12]
    end else if (fault_rise) begin
      restart_pend_ff <= restart_ff; // [RULE_14] [RULE_15]
    end
  end

  // ---------------------------------------------------------------
  // Enable register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      en_ff      <= pps_pkg::EN_POR; // [RULE_01] [RULE_16]
      restart_ff <= pps_pkg::RESTART_POR;
      seq_inh_ff <= pps_pkg::SEQ_INH_POR;
    end else if (en_fall) begin
      en_ff <= 3'h0; // [RULE_05] [RULE_06]
    end else if (fault_rise) begin
      en_ff      <= restart_ff ? EN_DEF : 3'h0; // [RULE_10]
      seq_inh_ff <= 1'b0; // [RULE_10]
    end else if (default_start) begin
      en_ff      <= EN_DEF; // [RULE_03] [RULE_22]
      seq_inh_ff <= 1'b0; // [RULE_03]
      restart_ff <= 1'b1; // [RULE_03]
    end else if (enable_wr.wr) begin
      en_ff      <= enable_wr.en; // [RULE_07]
      restart_ff <= enable_wr.restart; // [RULE_11]
      seq_inh_ff <= SEQ_CAPABLE ? enable_wr.seq_inh : 1'b0; // [RULE_22]
    end
  end

  // ---------------------------------------------------------------
  // Voltage registers
  // ---------------------------------------------------------------
  for (genvar i = 0; i < pps_pkg::NUM_SUP; i++) begin : g_vsel
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        vsel_ff[i] <= vsel_default(i); // [RULE_01]
      end else if (fault_rise || default_start) begin
        vsel_ff[i] <= vsel_default(i); // [RULE_03] [RULE_10]
      end else if (vsel_wr[i]) begin
        vsel_ff[i] <= vsel_wdata; // [RULE_09]
      end
    end
  end

  // ---------------------------------------------------------------
  // Power state
  // ---------------------------------------------------------------
  always_comb begin
    if (fault_s) begin
      nxt_state = pps_pkg::PPS_FAULT; // [RULE_14] [RULE_15]
    end else if (en_fall || host_all_off) begin
      nxt_state = pps_pkg::PPS_OFF; // [RULE_12]
    end else if (default_start || (enable_wr.wr && enable_wr.en != 3'h0)) begin
      nxt_state = pps_pkg::PPS_RUN;
    end else if (state_ff == pps_pkg::PPS_FAULT) begin
      nxt_state = (en_ff != 3'h0) ? pps_pkg::PPS_RUN : pps_pkg::PPS_OFF;
    end else begin
      nxt_state = state_ff;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= pps_pkg::PPS_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // Sequencing chain and supply switches
  // ---------------------------------------------------------------
  assign seq_off     = ~SEQ_CAPABLE | seq_inh_ff; // [RULE_24] [RULE_22]
  assign seq_gate[0] = 1'b1;
  for (genvar i = 1; i < pps_pkg::NUM_SUP; i++) begin : g_chain
    // Each enabled upstream supply must be good before the next starts
    assign seq_gate[i] = seq_gate[i-1] &
      (seq_off | ~en_ff[i-1] | pg_s[i-1]); // [RULE_23] [RULE_07]
  end

  always_comb begin
    if (state_ff == pps_pkg::PPS_RUN && !fault_s && !en_fall) begin
      nxt_supply = en_ff & seq_gate; // [RULE_07]
    end else begin
      nxt_supply = 3'h0; // [RULE_05] [RULE_10]
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      supply_on_ff <= 3'h0;
      bias_on_ff   <= 1'b0;
    end else begin
      supply_on_ff <= nxt_supply;
      bias_on_ff   <= (nxt_state != pps_pkg::PPS_OFF); // [RULE_14] [RULE_15]
    end
  end

  // ---------------------------------------------------------------
  // Status register and fault flags
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ot_flag_ff <= pps_pkg::FLAG_POR; // [RULE_16]
      uv_flag_ff <= pps_pkg::FLAG_POR;
    end else begin
      // A live condition wins over the clear
      ot_flag_ff <= sync2_ff[pps_pkg::SYNC_OT] | // [RULE_19]
        (ot_flag_ff & ~(status_wr.wr & status_wr.clr_ot)); // [RULE_13]
      uv_flag_ff <= sync2_ff[pps_pkg::SYNC_UV] | // [RULE_19]
        (uv_flag_ff & ~(status_wr.wr & status_wr.clr_uv)); // [RULE_13]
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      int_en_ff <= pps_pkg::INT_EN_POR; // [RULE_21]
    end else if (status_wr.wr) begin
      int_en_ff <= status_wr.int_en;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pgood_ff <= 3'h0;
    end else begin
      pgood_ff <= pg_s; // [RULE_17]
    end
  end

  // ---------------------------------------------------------------
  // Open-drain interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_oe_n_ff <= 1'b1;
      irq_lvl_ff  <= 1'b0;
    end else begin
      irq_lvl_ff  <= 1'b0;
      // Restart bit plays no part here [RULE_20]
      irq_oe_n_ff <= ~(int_en_ff & (ot_flag_ff | uv_flag_ff)); // [RULE_18]
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign enable_rd.en        = en_ff;
  assign enable_rd.restart   = restart_ff;
  assign enable_rd.seq_inh   = seq_inh_ff;
  assign status_rd.int_en    = int_en_ff;
  assign status_rd.uv_flag   = uv_flag_ff;
  assign status_rd.ot_flag   = ot_flag_ff;
  assign status_rd.pgood     = pgood_ff;
  assign vsel_code           = vsel_ff;
  assign supply_on           = supply_on_ff;
  assign bias_on             = bias_on_ff;
  assign fault_irq_n_o       = irq_lvl_ff;
  assign fault_irq_n_oe_n    = irq_oe_n_ff;

endmodule : pps_power_sequencer

/* File: verif/pps_analog_model.sv */
// Purpose: Power-good comparators of the three regulator stages
// Assumes: An output settles PG_DLY+1 cycles after its switch-on
// Notes:   Power good drops one cycle after switch-off
`timescale 1ns/1ps
module pps_analog_model #(
  parameter int PG_DLY = 5
) (
  input  wire logic       mclk,      // Clock
  input  wire logic [2:0] supply_on, // Switch-on
  output logic      [2:0] pgood_cmp  // Output valid
);
  int cnt [3];

  // Ramp counter per output; slow ramps come from a larger PG_DLY
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 3; i++) begin
      cnt[i]       <= supply_on[i] ? cnt[i] + 1 : 0;
      pgood_cmp[i] <= supply_on[i] && cnt[i] >= PG_DLY;
    end
  end
endmodule : pps_analog_model

/* File: verif/pps_seq_chk_sva.sv */
// Purpose: Port-level checks of the power sequencer
// Assumes: Host never mixes pin edges with register writes
// Notes:   Bound into every sequencer instance
`timescale 1ns/1ps
module pps_seq_chk #(
  parameter bit SEQ_CAPABLE = 1'b1
) (
  input wire logic                    mclk,             // Clock
  input wire logic                    rst_b,            // Reset
  input wire logic                    en_pin,           // Enable pin
  input wire logic                    overtemp_cmp,     // Hot
  input wire logic                    undervolt_cmp,    // Low input
  input wire logic [2:0]              pgood_cmp,        // Power good
  input wire pps_pkg::pps_stwr_type   status_wr,        // Status write
  input wire pps_pkg::pps_enable_type enable_rd,        // Enable reg
  input wire pps_pkg::pps_status_type status_rd,        // Status reg
  input wire logic [2:0]              supply_on,        // Switch-on
  input wire logic                    bias_on,          // Bias
  input wire logic                    fault_irq_n_o,    // Pin value
  input wire logic                    fault_irq_n_oe_n  // Pin enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic [2:0] en_def;
  logic       irq_want;
  logic       clr_ot;
  assign en_def   = SEQ_CAPABLE ? pps_pkg::EN_DEF_SEQ : pps_pkg::EN_DEF_NOSEQ;
  assign irq_want = status_rd.int_en & (status_rd.uv_flag | status_rd.ot_flag);
  assign clr_ot   = status_wr.wr & status_wr.clr_ot;

  property p_rise;
    $rose(en_pin) ##1 en_pin [*3] |=>
      enable_rd.en == en_def && enable_rd.restart;
  endproperty
  a_rise: assert property (p_rise)
    else $error("default startup missing");
  property p_fall;
    $fell(en_pin) ##1 !en_pin [*3] |=> enable_rd.en == 3'h0
      && supply_on == 3'h0 && !bias_on;
  endproperty
  a_fall: assert property (p_fall)
    else $error("pin shutdown incomplete");
  property p_ot;
    overtemp_cmp [*5] |-> supply_on == 3'h0 && status_rd.ot_flag;
  endproperty
  a_ot: assert property (p_ot)
    else $error("hot die left outputs on");
  property p_uv;
    undervolt_cmp [*5] |-> supply_on == 3'h0 && status_rd.uv_flag;
  endproperty
  a_uv: assert property (p_uv)
    else $error("low input left outputs on");
  property p_irq;
    1'b1 |=> fault_irq_n_oe_n == !$past(irq_want);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt pin wrong");
  property p_od;
    fault_irq_n_o == 1'b0;
  endproperty
  a_od: assert property (p_od)
    else $error("interrupt pin drives high");
  property p_pg;
    $stable(pgood_cmp) [*4] |-> status_rd.pgood == pgood_cmp;
  endproperty
  a_pg: assert property (p_pg)
    else $error("power good flag stale");
  property p_chain;
    $rose(supply_on[2]) && !$past(enable_rd.seq_inh)
      && $past(enable_rd.en[1]) |-> supply_on[1];
  endproperty
  a_chain: assert property (p_chain)
    else $error("third supply jumped the chain");
  property p_en;
    (supply_on & ~$past(enable_rd.en)) == 3'h0;
  endproperty
  a_en: assert property (p_en)
    else $error("supply on without enable");
  property p_keep;
    status_rd.ot_flag && !clr_ot |=> status_rd.ot_flag;
  endproperty
  a_keep: assert property (p_keep)
    else $error("flag lost without clear");
  property p_clr;
    (!overtemp_cmp) [*3] ##0 clr_ot |=> !status_rd.ot_flag;
  endproperty
  a_clr: assert property (p_clr)
    else $error("echo clear ignored");
  c_rise: cover property (p_rise);
  c_ot: cover property (overtemp_cmp [*5]);
  c_clr: cover property ((!overtemp_cmp) [*3] ##0 clr_ot);
endmodule : pps_seq_chk

bind pps_power_sequencer pps_seq_chk #(.SEQ_CAPABLE(SEQ_CAPABLE)) u_chk (
  .mclk(mclk), .rst_b(rst_b), .en_pin(en_pin),
  .overtemp_cmp(overtemp_cmp), .undervolt_cmp(undervolt_cmp),
  .pgood_cmp(pgood_cmp), .status_wr(status_wr), .enable_rd(enable_rd),
  .status_rd(status_rd), .supply_on(supply_on), .bias_on(bias_on),
  .fault_irq_n_o(fault_irq_n_o), .fault_irq_n_oe_n(fault_irq_n_oe_n));

/* File: verif/tb.sv */
// Purpose: Directed test of the power sequencer
// Assumes: Open-drain interrupt pin has a pull-up
// Notes:   Analog stages come from the partner model
`timescale 1ns/1ps
module tb;
  logic                    mclk, rst_b, en_pin, overtemp_cmp, undervolt_cmp;
  logic [2:0]              pgood_cmp, vsel_wr, supply_on;
  logic [7:0]              vsel_wdata;
  logic [2:0][7:0]         vsel_code;
  logic                    bias_on, irq_o, irq_oe_n, irq_pin;
  pps_pkg::pps_enwr_type   enable_wr;
  pps_pkg::pps_stwr_type   status_wr;
  pps_pkg::pps_enable_type enable_rd;
  pps_pkg::pps_status_type status_rd;
  int                      error_cnt, checks_done;
  logic [2:0]              supply_on_ns;
  pps_pkg::pps_enable_type enable_rd_ns;

  assign irq_pin = irq_oe_n ? 1'b1 : irq_o;

  pps_power_sequencer dut (.mclk(mclk), .rst_b(rst_b), .en_pin(en_pin),
    .overtemp_cmp(overtemp_cmp), .undervolt_cmp(undervolt_cmp),
    .pgood_cmp(pgood_cmp), .enable_wr(enable_wr), .status_wr(status_wr),
    .vsel_wr(vsel_wr), .vsel_wdata(vsel_wdata), .enable_rd(enable_rd),
    .status_rd(status_rd), .vsel_code(vsel_code), .supply_on(supply_on),
    .bias_on(bias_on), .fault_irq_n_o(irq_o), .fault_irq_n_oe_n(irq_oe_n));
  // Variant without sequencing, same stimulus
  pps_power_sequencer #(.SEQ_CAPABLE(1'b0)) dut_ns (.mclk(mclk),
    .rst_b(rst_b), .en_pin(en_pin), .overtemp_cmp(overtemp_cmp),
    .undervolt_cmp(undervolt_cmp), .pgood_cmp(pgood_cmp),
    .enable_wr(enable_wr), .status_wr(status_wr), .vsel_wr(vsel_wr),
    .vsel_wdata(vsel_wdata), .enable_rd(enable_rd_ns), .status_rd(),
    .vsel_code(), .supply_on(supply_on_ns), .bias_on(),
    .fault_irq_n_o(), .fault_irq_n_oe_n());
  pps_analog_model #(.PG_DLY(5)) u_ana (.mclk(mclk),
    .supply_on(supply_on), .pgood_cmp(pgood_cmp));

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_en(input logic r, input logic s, input logic [2:0] e);
    @(posedge mclk);
    enable_wr <= {1'b1, r, s, e};
    @(posedge mclk);
    enable_wr.wr <= 1'b0;
  endtask : wr_en
  task automatic wr_st(input logic i, input logic u, input logic o);
    @(posedge mclk);
    status_wr <= {1'b1, i, u, o};
    @(posedge mclk);
    status_wr.wr <= 1'b0;
  endtask : wr_st
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end
  initial begin
    {rst_b, overtemp_cmp, undervolt_cmp, vsel_wr, vsel_wdata} = '0;
    {enable_wr, status_wr, error_cnt, checks_done} = '0;
    en_pin = 1'b1;
    tick(11);
    chk(enable_rd, 5'h10);
    chk(status_rd, 6'h00);
    chk(vsel_code, 24'hD1451C);
    chk({bias_on, supply_on, irq_pin}, 5'h01);
    @(posedge mclk) rst_b <= 1'b1;
    tick(40);
    chk(supply_on, 3'h7);
    chk(status_rd.pgood, 3'h7);
    chk({enable_rd_ns, supply_on_ns}, 8'h89);
    @(posedge mclk) {vsel_wr, vsel_wdata} <= {3'h2, 8'h20};
    @(posedge mclk) vsel_wr <= 3'h0;
    tick(2);
    chk(vsel_code[1], 8'h20);
    @(posedge mclk) en_pin <= 1'b0;
    tick(6);
    chk({enable_rd.en, supply_on, bias_on}, 7'h00);
    @(posedge mclk) en_pin <= 1'b1;
    tick(6);
    chk(enable_rd, 5'h17);
    chk(vsel_code[1], 8'h45);
    tick(40);
    wr_en(1'b1, 1'b0, 3'h0);
    tick(4);
    chk({supply_on, bias_on}, 4'h0);
    @(posedge mclk) en_pin <= 1'b0; // Host writes settled first
    tick(6);
    chk({enable_rd, supply_on, bias_on}, 9'h100);
    wr_en(1'b1, 1'b0, 3'h5);
    tick(3);
    chk(supply_on, 3'h1);
    tick(15);
    chk(supply_on, 3'h5);
    wr_en(1'b1, 1'b0, 3'h0);
    tick(4);
    wr_en(1'b1, 1'b1, 3'h6);
    tick(3);
    chk(supply_on, 3'h6);
    chk(enable_rd, 5'h1E);
    chk({enable_rd_ns, supply_on_ns}, 8'hB6);
    wr_en(1'b1, 1'b0, 3'h0);
    tick(4);
    wr_st(1'b1, 1'b0, 1'b0);
    wr_en(1'b1, 1'b0, 3'h7);
    tick(40);
    @(posedge mclk) overtemp_cmp <= 1'b1;
    tick(6);
    chk({supply_on, bias_on, status_rd.ot_flag, irq_pin}, 6'h06);
    chk(enable_rd, 5'h17);
    wr_st(1'b1, 1'b0, 1'b1);
    tick(3);
    chk(status_rd.ot_flag, 1'b1);
    @(posedge mclk) overtemp_cmp <= 1'b0;
    tick(40);
    chk({supply_on, status_rd.ot_flag}, 4'hF);
    wr_st(1'b1, 1'b0, 1'b1);
    tick(3);
    chk({status_rd.ot_flag, irq_pin}, 2'h1);
    wr_en(1'b0, 1'b0, 3'h7);
    tick(40);
    @(posedge mclk) undervolt_cmp <= 1'b1;
    tick(6);
    chk({enable_rd, supply_on, status_rd.uv_flag}, 9'h001);
    @(posedge mclk) undervolt_cmp <= 1'b0;
    tick(40);
    chk({supply_on, irq_pin}, 4'h0);
    wr_st(1'b0, 1'b0, 1'b0);
    tick(3);
    chk(irq_pin, 1'b1);
    @(posedge mclk) rst_b <= 1'b0;
    tick(2);
    @(posedge mclk) rst_b <= 1'b1;
    tick(10);
    chk({status_rd.uv_flag, supply_on}, 4'h0);
    summarize();
  end
endmodule : tb
